// file: rtl/afs_flags.sv
// Warning-flag and protection-flag registers with their two output lines.
// Assumes the serial port front end delivers decoded byte accesses on i_mclk.
// Contract
// - Warning bit 7 is forced to one while the address is unassigned.
// - Unassigned flag clears after address set, then write one, then write zero.
// - Unassigned flag reads one after reset, zero once cleared after address assigned.
// - Bit 6 sets when protected configuration group check fails.
// - Bit 5 sets on uncorrectable double-bit OTP error only.
// - Bit 4 is a stored force bit driving the warning output, default zero.
// - Bit 3 set while thermal shutdown active, default zero.
// - Bit 2 sets only on entry into sleep, not again while sleep holds.
// - Bit 1 sets above second threshold, holds below it until cleared, zero when disabled.
// - Bit 0 sets above first threshold, holds below it until cleared, zero when disabled.
// - Protection-flag register at 0x21 reports the cause of fault output.
// - Protection flags clear on write one, write zero leaves them.
// - Protection bit 4 stores the written value directly.
// - Warning flags clear on write one, bit 7 on one then zero; bit 4 stores the written value.
`timescale 1ns/1ps
module afs_flags (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_addr_assigned,
    input  wire logic       i_parity_invalid,
    input  wire logic       i_ecc_double_err,
    input  wire logic       i_sleep_ctrl,
    input  wire logic       i_ts1_en,
    input  wire logic       i_ts2_en,
    input  wire logic       i_tsd_active,
    input  wire logic       i_ot1_over,
    input  wire logic       i_ot2_over,
    input  wire logic [7:0] i_prot_cause,
    output logic      [7:0] o_reg_rdata,
    output logic            o_warning,
    output logic            o_fault
);

    logic [7:0] warn_reg;
    logic [7:0] warn_next;
    logic [7:0] warn_set;
    logic [7:0] warn_w1c;
    logic [7:0] warn_dis;
    logic       arm_reg;
    logic       sleep_prev_reg;
    logic [7:0] prot_reg;
    logic [7:0] prot_next;
    logic [2:0] pin_sync;
    logic       tsd_s;
    logic       ot1_s;
    logic       ot2_s;
    logic       wr_warn;
    logic       wr_prot;

    ////////////////////////////////////////////////////////////////////////
    // Comparator pins into the clock domain
    afs_sync3 #(
        .WIDTH (afs_pkg::SYNC_WIDTH)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async ({i_ot2_over, i_ot1_over, i_tsd_active}),
        .o_sync  (pin_sync)
    );

    assign tsd_s = pin_sync[0];
    assign ot1_s = pin_sync[1];
    assign ot2_s = pin_sync[2];

    // Write decode
    assign wr_warn = i_reg_wr && (i_reg_addr == afs_pkg::ADDR_WARN);
    assign wr_prot = i_reg_wr && (i_reg_addr == afs_pkg::ADDR_PROT);

    ////////////////////////////////////////////////////////////////////////
    // Warning-flag set, clear and disable terms
    always_comb
    begin
        warn_set = 8'h00;
        warn_set[afs_pkg::WARN_PARITY] = i_parity_invalid;
        warn_set[afs_pkg::WARN_ECC]    = i_ecc_double_err;
        warn_set[afs_pkg::WARN_TSD]    = tsd_s;
        warn_set[afs_pkg::WARN_SLEEP]  = i_sleep_ctrl && !sleep_prev_reg;
        warn_set[afs_pkg::WARN_OT2]    = ot2_s && i_ts2_en;
        warn_set[afs_pkg::WARN_OT1]    = ot1_s && i_ts1_en;
        warn_w1c = wr_warn ? (i_reg_wdata & afs_pkg::WARN_W1C_MASK) : 8'h00;
        warn_dis = 8'h00;
        warn_dis[afs_pkg::WARN_OT2] = !i_ts2_en;
        warn_dis[afs_pkg::WARN_OT1] = !i_ts1_en;
        // Set wins over a clear in the same cycle
        warn_next = (warn_set | (warn_reg & ~warn_w1c & ~warn_dis)) & afs_pkg::WARN_W1C_MASK;
        warn_next[afs_pkg::WARN_FORCE]    = wr_warn ? i_reg_wdata[afs_pkg::WARN_FORCE]
                                                    : warn_reg[afs_pkg::WARN_FORCE];
        warn_next[afs_pkg::WARN_UNASSIGN] = warn_reg[afs_pkg::WARN_UNASSIGN];
        if (!i_addr_assigned)
            warn_next[afs_pkg::WARN_UNASSIGN] = 1'b1;
        else if (wr_warn && !i_reg_wdata[afs_pkg::WARN_UNASSIGN] && arm_reg)
            warn_next[afs_pkg::WARN_UNASSIGN] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Warning-flag register
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            warn_reg <= afs_pkg::WARN_RST;
        else
            warn_reg <= warn_next;
    end

    // Arming for the one-then-zero clear of the unassigned flag
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            arm_reg <= 1'b0;
        else if (!i_addr_assigned)
            arm_reg <= 1'b0;
        else if (wr_warn)
            arm_reg <= i_reg_wdata[afs_pkg::WARN_UNASSIGN];
    end

    // Sleep control history for entry detection
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            sleep_prev_reg <= 1'b0;
        else
            sleep_prev_reg <= i_sleep_ctrl;
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection-flag register; reserved bits 7:6 stay zero
    always_comb
    begin
        prot_next = ((i_prot_cause | prot_reg) & afs_pkg::PROT_W1C_MASK);
        if (wr_prot)
            prot_next = (i_prot_cause | (prot_reg & ~i_reg_wdata)) & afs_pkg::PROT_W1C_MASK;
        prot_next[afs_pkg::PROT_FORCE] = wr_prot ? i_reg_wdata[afs_pkg::PROT_FORCE]
                                                 : prot_reg[afs_pkg::PROT_FORCE];
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            prot_reg <= afs_pkg::PROT_RST;
        else
            prot_reg <= prot_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output lines follow the flag registers one cycle later
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_warning <= 1'b0;
            o_fault   <= 1'b0;
        end
        else
        begin
            o_warning <= |warn_reg;
            o_fault   <= |prot_reg;
        end
    end

    // Read data, unmapped offsets read zero
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_reg_rdata <= afs_pkg::RDATA_RST;
        else if (i_reg_addr == afs_pkg::ADDR_WARN)
            o_reg_rdata <= warn_reg;
        else if (i_reg_addr == afs_pkg::ADDR_PROT)
            o_reg_rdata <= prot_reg;
        else
            o_reg_rdata <= afs_pkg::RDATA_RST;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_unassigned;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_addr_assigned |=> warn_reg[7];
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned flag not set");

    property p_ar_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $fell(warn_reg[7]) |-> $past(i_addr_assigned) && $past(wr_warn) && !$past(i_reg_wdata[7]) && $past(arm_reg);
    endproperty
    a_ar_clear: assert property (p_ar_clear) else $error("unassigned flag cleared early");

    property p_parity;
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_parity_invalid |=> warn_reg[6];
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag missing");

    property p_ecc;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(warn_reg[5]) |-> $past(i_ecc_double_err);
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc flag without cause");

    property p_force;
        @(posedge i_mclk) disable iff (!i_rst_n)
        wr_warn |=> (warn_reg[4] == $past(i_reg_wdata[4])) ##1 (o_warning || !$past(warn_reg[4]));
    endproperty
    a_force: assert property (p_force) else $error("force bit wrong");

    property p_tsd;
        @(posedge i_mclk) disable iff (!i_rst_n)
        tsd_s |=> warn_reg[3];
    endproperty
    a_tsd: assert property (p_tsd) else $error("thermal flag missing");

    property p_sleep;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(warn_reg[2]) |-> $past(i_sleep_ctrl) && !$past(sleep_prev_reg);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag not on entry");

    property p_ot2;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_ts2_en |=> !warn_reg[1];
    endproperty
    a_ot2: assert property (p_ot2) else $error("second overtemp flag while disabled");

    property p_ot1;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (ot1_s && i_ts1_en) |=> warn_reg[0] ##1 o_warning;
    endproperty
    a_ot1: assert property (p_ot1) else $error("first overtemp flag missing");

    property p_prot_keep;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (wr_prot && !i_reg_wdata[0] && prot_reg[0]) |=> prot_reg[0];
    endproperty
    a_prot_keep: assert property (p_prot_keep) else $error("protection flag lost");

    property p_prot_force;
        @(posedge i_mclk) disable iff (!i_rst_n)
        wr_prot |=> prot_reg[4] == $past(i_reg_wdata[4]);
    endproperty
    a_prot_force: assert property (p_prot_force) else $error("protection force wrong");

    property p_warn_idle;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (warn_reg == 8'h00) |=> !o_warning;
    endproperty
    a_warn_idle: assert property (p_warn_idle) else $error("warning output without flag");

endmodule : afs_flags

// file: pkg/afs_pkg.sv
// Constants for the warning-flag and protection-flag register pair.
// Assumes an 8-bit register port with byte-wide offsets.
package afs_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_WARN      = 8'h20;
    localparam logic [7:0] ADDR_PROT      = 8'h21;
    // Warning-flag field positions
    localparam int         WARN_UNASSIGN  = 7;
    localparam int         WARN_PARITY    = 6;
    localparam int         WARN_ECC       = 5;
    localparam int         WARN_FORCE     = 4;
    localparam int         WARN_TSD       = 3;
    localparam int         WARN_SLEEP     = 2;
    localparam int         WARN_OT2       = 1;
    localparam int         WARN_OT1       = 0;
    // Protection-flag field positions
    localparam int         PROT_FORCE     = 4;
    // Write-one-to-clear masks, force bits excluded
    localparam logic [7:0] WARN_W1C_MASK  = 8'h6F;
    localparam logic [7:0] PROT_W1C_MASK  = 8'h2F;
    // Reset values
    localparam logic [7:0] WARN_RST       = 8'h80;
    localparam logic [7:0] PROT_RST       = 8'h00;
    localparam logic [7:0] RDATA_RST      = 8'h00;
    // Pin synchroniser depth and width
    localparam int         SYNC_STAGES    = 3;
    localparam int         SYNC_WIDTH     = 3;
endpackage : afs_pkg

// file: rtl/afs_sync3.sv
// Three-flop synchroniser with agreement filter for asynchronous pins.
// Assumes inputs are slow levels from comparators outside the clock domain.
`timescale 1ns/1ps
module afs_sync3 #(
    parameter int WIDTH = afs_pkg::SYNC_WIDTH
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    ////////////////////////////////////////////////////////////////////////
    // Three-stage shift; first stage feeds only the second
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            meta_reg   <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end
        else
        begin
            meta_reg   <= i_async;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output follows a bit only where stages two and three agree
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_sync <= '0;
        else
            o_sync <= (stage2_reg & ~(stage2_reg ^ stage3_reg)) | (o_sync & (stage2_reg ^ stage3_reg));
    end

endmodule : afs_sync3

// file: tb/afs_host_model.sv
// Host model for the byte-wide register port of the flag block.
// Assumes calls are made just after a rising edge of i_mclk.
`timescale 1ns/1ps
module afs_host_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr
);
    ////////////////////////////////////////////////////////////////
    // Idle port at time zero
    initial
    begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
    end
    // One write, strobe high for one edge; clears go as written ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_mclk);
        o_wr    <= 1'b0;
        o_wdata <= ~d; // Stale data never mirrors the last byte
    endtask : wr
    // Present an offset and take the registered answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        repeat (2) @(posedge i_mclk);
        #1 d = i_rdata;
    endtask : rd
endmodule : afs_host_model

// file: tb/afs_flags_tb.sv
// Self-checking bench for the warning and protection flag registers.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module afs_flags_tb;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       asg = 1'b0;
    logic       par = 1'b0;
    logic       ecc = 1'b0;
    logic       slp = 1'b0;
    logic       en1 = 1'b1;
    logic       en2 = 1'b1;
    logic       thermal_shutdown_flag = 1'b0;
    logic       ot1 = 1'b0;
    logic       ot2 = 1'b0;
    logic [7:0] cause = 8'h00;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic [7:0] rdata;
    logic       warn;
    logic       flt;
    int         n_fail = 0;
    int         check_count = 0;
    ////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    always #50 mclk = ~mclk;
    afs_flags afs_flags_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_addr_assigned(asg), .i_parity_invalid(par),
        .i_ecc_double_err(ecc), .i_sleep_ctrl(slp), .i_ts1_en(en1), .i_ts2_en(en2),
        .i_tsd_active(thermal_shutdown_flag), .i_ot1_over(ot1), .i_ot2_over(ot2), .i_prot_cause(cause),
        .o_reg_rdata(rdata), .o_warning(warn), .o_fault(flt));
    afs_host_model afs_host_model_inst (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr));
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // Compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // Read an offset and compare
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        afs_host_model_inst.rd(a, v);
        chk(v, exp);
    endtask : chk_rd
    // Drive the cause input of one warning bit
    task automatic set_src(input int b, input logic v);
        @(posedge mclk);
        case (b)
            6: par <= v;
            5: ecc <= v;
            3: thermal_shutdown_flag <= v;
            2: slp <= v;
            1: ot2 <= v;
            default: ot1 <= v;
        endcase
        repeat (8) @(posedge mclk);
    endtask : set_src
    // Raise one flag, hold through a zero write, clear with a one
    task automatic t_flag(input int b);
        logic [7:0] m;
        m = 8'h01 << b;
        set_src(b, 1'b1);
        chk_rd(8'h20, m);
        chk({7'h00, warn}, 8'h01);
        afs_host_model_inst.wr(8'h20, 8'h00);
        chk_rd(8'h20, m);
        if (b != 2)
            set_src(b, 1'b0);
        afs_host_model_inst.wr(8'h20, m);
        chk_rd(8'h20, 8'h00);
        chk({7'h00, warn}, 8'h00);
        set_src(b, 1'b0);
        $display("test flag %0d done", b);
    endtask : t_flag
    // Reset values of both registers and both output lines
    task automatic t_reset();
        chk_rd(8'h20, 8'h80);
        chk_rd(8'h21, 8'h00);
        chk_rd(8'h22, 8'h00);
        chk({7'h00, warn}, 8'h01);
        chk({7'h00, flt}, 8'h00);
        $display("test reset done");
    endtask : t_reset
    // Unassigned flag refuses its clear until assigned, returns when unassigned
    task automatic t_address();
        afs_host_model_inst.wr(8'h20, 8'h80);
        afs_host_model_inst.wr(8'h20, 8'h00);
        chk_rd(8'h20, 8'h80);
        @(posedge mclk);
        asg <= 1'b1;
        chk_rd(8'h20, 8'h80);
        afs_host_model_inst.wr(8'h20, 8'h80);
        afs_host_model_inst.wr(8'h20, 8'h00);
        chk_rd(8'h20, 8'h00);
        chk({7'h00, warn}, 8'h00);
        @(posedge mclk);
        asg <= 1'b0;
        chk_rd(8'h20, 8'h80);
        @(posedge mclk);
        asg <= 1'b1;
        afs_host_model_inst.wr(8'h20, 8'h80);
        afs_host_model_inst.wr(8'h20, 8'h00);
        chk_rd(8'h20, 8'h00);
        $display("test address done");
    endtask : t_address
    // Overtemperature flags drop and stay low while their enables are off
    task automatic t_disabled();
        set_src(0, 1'b1);
        chk_rd(8'h20, 8'h01);
        @(posedge mclk);
        en1 <= 1'b0;
        en2 <= 1'b0;
        set_src(1, 1'b1);
        chk_rd(8'h20, 8'h00);
        set_src(0, 1'b0);
        set_src(1, 1'b0);
        $display("test disabled done");
    endtask : t_disabled
    // Force bit stores the written value and drives the warning line
    task automatic t_force();
        afs_host_model_inst.wr(8'h20, 8'h10);
        afs_host_model_inst.wr(8'h20, 8'h10);
        chk_rd(8'h20, 8'h10);
        chk({7'h00, warn}, 8'h01);
        afs_host_model_inst.wr(8'h20, 8'h00);
        chk_rd(8'h20, 8'h00);
        chk({7'h00, warn}, 8'h00);
        $display("test force done");
    endtask : t_force
    // Protection flags: sticky causes, write-one clear, stored force bit
    task automatic t_prot();
        @(posedge mclk);
        cause <= 8'hFF;
        @(posedge mclk);
        cause <= 8'h00;
        chk_rd(8'h21, 8'h2F);
        chk({7'h00, flt}, 8'h01);
        afs_host_model_inst.wr(8'h21, 8'h00);
        chk_rd(8'h21, 8'h2F);
        afs_host_model_inst.wr(8'h21, 8'h0F);
        chk_rd(8'h21, 8'h20);
        afs_host_model_inst.wr(8'h21, 8'hD0);
        chk_rd(8'h21, 8'h30);
        afs_host_model_inst.wr(8'h21, 8'h30);
        chk_rd(8'h21, 8'h10);
        afs_host_model_inst.wr(8'h21, 8'h00);
        chk_rd(8'h21, 8'h00);
        chk({7'h00, flt}, 8'h00);
        $display("test protection done");
    endtask : t_prot
    ////////////////////////////////////////////////////////////////
    // Hang guard
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_address();
        t_flag(6);
        t_flag(5);
        t_flag(3);
        t_flag(2);
        t_flag(1);
        t_flag(0);
        t_disabled();
        t_force();
        t_prot();
        stop_test();
    end
endmodule : afs_flags_tb
